// >>> logic/rdi_defines.svh
`ifndef RDI_DEFINES_SVH
`define RDI_DEFINES_SVH

// Configuration register offsets
`define RDI_ADDR_CFG_A      8'h15
`define RDI_ADDR_CFG_C      8'h17

// Configuration A field positions
`define RDI_A_CHECK_BIT     0
`define RDI_A_LANES_BIT     4
`define RDI_A_MODE_BIT      5
`define RDI_A_BUSY_BIT      7
`define RDI_A_WR_MASK       8'h31

// Configuration C field positions
`define RDI_C_DRIVE_LSB     0
`define RDI_C_DRIVE_MSB     1
`define RDI_C_SELFCLK_BIT   4
`define RDI_C_WR_MASK       8'h13

// Reset values
`define RDI_CFG_A_RESET     8'h00
`define RDI_CFG_C_RESET     8'h01

// Drive amplitude codes: 185, 240 and 325 mV p-p
`define RDI_DRIVE_LOW       2'h0
`define RDI_DRIVE_MID       2'h1
`define RDI_DRIVE_HIGH      2'h2

// Fixed interface check pattern
`define RDI_CHECK_PATTERN   20'hAC5D6

// Field widths and record lengths in bits
`define RDI_RES_W           20
`define RDI_EXT_W           24
`define RDI_CRC_W           24
`define RDI_REC_W           48
`define RDI_LEN_SPI         6'h30
`define RDI_LEN_DIFF        6'h2C
`define RDI_LEN_CHECK       6'h14

// Active lane counts
`define RDI_LANES_ONE       3'h1
`define RDI_LANES_TWO       3'h2
`define RDI_LANES_FOUR      3'h4

`endif

// >>> logic/rdi_pkg.sv
`default_nettype none

package rdi_pkg;

    // Shifter states
    typedef enum logic {
        RDI_IDLE,
        RDI_SHIFT
    } rdi_state_e;

    // Output drive amplitude code
    typedef logic [1:0] rdi_drive_t;

endpackage

`default_nettype wire

// >>> logic/rdi_sync.sv
`timescale 1ns/1ns
`default_nettype none

module rdi_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output var  logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_q;

    // Two flops; only the second stage is visible to logic
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            stage1_q <= RST_VAL;
            syncOut  <= RST_VAL;
        end else begin
            stage1_q <= asyncIn;
            syncOut  <= stage1_q;
        end
    end

endmodule

`default_nettype wire

// >>> logic/rdi_crc.sv
`timescale 1ns/1ns
`default_nettype none
`include "rdi_defines.svh"

module rdi_crc #(
    parameter logic [`RDI_CRC_W-1:0] POLY = 24'h864CFB,
    parameter logic [`RDI_CRC_W-1:0] SEED = 24'hFFFFFF
) (
    input  wire logic [`RDI_EXT_W-1:0] dataIn,
    output logic      [`RDI_CRC_W-1:0] crcOut
);

    // Bitwise MSB-first CRC over one word; fresh seed per record
    always_comb begin
        logic [`RDI_CRC_W-1:0] acc;
        logic                  fb;
        acc = SEED;
        fb  = 1'b0;
        for (int i = `RDI_EXT_W - 1; i >= 0; i--) begin
            fb  = acc[`RDI_CRC_W-1] ^ dataIn[i];
            acc = {acc[`RDI_CRC_W-2:0], 1'b0};
            if (fb) begin
                acc = acc ^ POLY;
            end
        end
        crcOut = acc;
    end

endmodule

`default_nettype wire

// >>> logic/rdi_result_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "rdi_defines.svh"

// Functional notes
// [R01] Check enable sends fixed 20-bit pattern
// [R02] Pattern 0xAC5D6; results resume when cleared
// [R03] No results consumed while check enabled
// [R04] Host enables check only when idle
// [R05] Three drive amplitudes, middle after reset
// [R06] Mode bit set selects CMOS serial
// [R07] CMOS mode disables all differential drivers
// [R08] Self clock, drive level ignored in CMOS
// [R09] One or four CMOS lanes, host clock
// [R10] Bits change on serial clock falling edge
// [R11] Lane bit resets 0; 1 means four
// [R12] Lane bit also sets differential lanes
// [R13] 24-bit CRC appended to every result record
// [R14] Result CRC separate from configuration checksum
// [R15] CMOS results sign extended to 24 bits
// [R16] MSB first; host may stop early
// [R17] CRC polynomial, seed, lane order parameters
// [R18] Mode and lanes change only between records
module rdi_result_port
    import rdi_pkg::*;
#(
    parameter logic [`RDI_CRC_W-1:0] CRC_POLY        = 24'h864CFB,
    parameter logic [`RDI_CRC_W-1:0] CRC_SEED        = 24'hFFFFFF,
    parameter bit                    LANE0_TAKES_MSB = 1'b1
) (
    input  wire logic                 clk_sys,
    input  wire logic                 sys_rst,
    // Configuration port register access
    input  wire logic                 cfgWrEn,
    input  wire logic [7:0]           cfgAddr,
    input  wire logic [7:0]           cfgWrData,
    output logic      [7:0]           cfgRdData,
    // Results from the FIFO
    input  wire logic                 resValid,
    input  wire logic [`RDI_RES_W-1:0] resData,
    output logic                      resReady,
    // Host pins
    input  wire logic                 result_serial_clock,
    input  wire logic                 resultSelect_n,
    // CMOS data lanes
    output logic      [3:0]           result_serial_out_lane,
    output logic      [3:0]           resultLaneOe,
    // Differential lanes and echo clock
    output logic      [1:0]           diffLanePos,
    output logic      [1:0]           diffLaneNeg,
    output logic                      echo_clock_out_pos,
    output logic                      echo_clock_out_neg,
    output logic      [1:0]           diffLaneEnable,
    output logic                      echoClockEnable,
    output rdi_drive_t                output_drive_level
);

    // Active lanes for a mode and lane bit
    function automatic logic [2:0] laneCount(input logic spiMode, input logic wide);
        if (!wide) begin
            laneCount = `RDI_LANES_ONE;
        end else if (spiMode) begin
            laneCount = `RDI_LANES_FOUR;
        end else begin
            laneCount = `RDI_LANES_TWO;
        end
    endfunction

    // Unsupported drive code falls back to the middle amplitude
    function automatic rdi_drive_t driveCode(input logic [1:0] raw);
        if (raw == `RDI_DRIVE_LOW || raw == `RDI_DRIVE_HIGH) begin
            driveCode = raw;
        end else begin
            driveCode = `RDI_DRIVE_MID;
        end
    endfunction

    logic [7:0]            cfgA_q;
    logic [7:0]            cfgC_q;
    rdi_state_e            state_q;
    rdi_state_e            state_d;
    logic [`RDI_REC_W-1:0] shift_q;
    logic [5:0]            remain_q;
    logic [5:0]            remain_d;
    logic                  spiLatched_q;
    logic [2:0]            lanes_q;
    logic                  sclkPrev_q;
    logic [3:0]            laneData_q;
    logic                  echo_q;
    rdi_drive_t            drive_q;
    logic                  sclkSync;
    logic                  selN_sync;

    // Pins cross into clk_sys before use
    // Flops reset to the pins' idle high, so no false select or fall after reset
    rdi_sync #(
        .WIDTH   (2),
        .RST_VAL (2'h3)
    ) u_pin_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .asyncIn ({result_serial_clock, resultSelect_n}),
        .syncOut ({sclkSync, selN_sync})
    );

    // Register decode
    wire        wrA        = cfgWrEn && (cfgAddr == `RDI_ADDR_CFG_A);
    wire        wrC        = cfgWrEn && (cfgAddr == `RDI_ADDR_CFG_C);
    wire        checkEn    = cfgA_q[`RDI_A_CHECK_BIT];
    wire        wideLanes  = cfgA_q[`RDI_A_LANES_BIT];
    wire        spiMode    = cfgA_q[`RDI_A_MODE_BIT];
    wire        selfClock  = cfgC_q[`RDI_C_SELFCLK_BIT];
    wire [1:0]  driveRaw   = cfgC_q[`RDI_C_DRIVE_MSB:`RDI_C_DRIVE_LSB];
    wire        busy       = (state_q == RDI_SHIFT);

    // Readback; busy shows the shifter is mid record
    wire [7:0]  rdA        = (cfgA_q & `RDI_A_WR_MASK) | ({7'h00, busy} << `RDI_A_BUSY_BIT);
    wire [7:0]  rdC        = cfgC_q & `RDI_C_WR_MASK;
    assign cfgRdData = (cfgAddr == `RDI_ADDR_CFG_A) ? rdA :
                       (cfgAddr == `RDI_ADDR_CFG_C) ? rdC :
                                                      8'h00;

    // Configuration A; bits outside the mask read zero, except bit 7, which reads busy
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cfgA_q <= `RDI_CFG_A_RESET; // R11
        end else if (wrA) begin
            cfgA_q <= cfgWrData & `RDI_A_WR_MASK; // R06
        end
    end

    // Configuration C; drive level and self clock
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cfgC_q <= `RDI_CFG_C_RESET; // R05
        end else if (wrC) begin
            cfgC_q <= cfgWrData & `RDI_C_WR_MASK;
        end
    end

    // Host clock edges, seen on the synchronised copy only
    wire        sclkFall   = sclkPrev_q && !sclkSync; // R10
    wire        selected   = !selN_sync;

    // Record assembly from the FIFO word
    wire [`RDI_EXT_W-1:0] resExt =
        {{(`RDI_EXT_W - `RDI_RES_W){resData[`RDI_RES_W-1]}}, resData}; // R15
    logic [`RDI_CRC_W-1:0] resCrc;

    // Result CRC has its own engine, apart from the configuration port
    rdi_crc #(
        .POLY (CRC_POLY),
        .SEED (CRC_SEED)
    ) u_result_crc (
        .dataIn (resExt),
        .crcOut (resCrc)
    ); // R14 R17

    // Record layouts, MSB first at the top of the shifter
    wire [`RDI_REC_W-1:0] recSpi   = {resExt, resCrc}; // R13 R15
    wire [`RDI_REC_W-1:0] recDiff  =
        {resData, resCrc, {(`RDI_REC_W - `RDI_RES_W - `RDI_CRC_W){1'b0}}}; // R13
    wire [`RDI_REC_W-1:0] recCheck =
        {`RDI_CHECK_PATTERN, {(`RDI_REC_W - `RDI_RES_W){1'b0}}}; // R01 R02

    // Start a record when idle, the host selects and something is ready
    wire        idleSel    = (state_q == RDI_IDLE) && selected;
    wire        loadCheck  = idleSel && checkEn; // R01
    wire        loadResult = idleSel && !checkEn && resValid;
    wire        load       = loadCheck || loadResult;

    // Results withheld while the pattern runs
    assign resReady = idleSel && !checkEn; // R03

    // Settings frozen per record
    wire [2:0]  loadLanes  = laneCount(spiMode, wideLanes); // R11 R12
    wire [5:0]  loadLen    = checkEn ? `RDI_LEN_CHECK :
                             spiMode ? `RDI_LEN_SPI   : `RDI_LEN_DIFF;
    wire [`RDI_REC_W-1:0] loadRec = checkEn ? recCheck :
                                    spiMode ? recSpi   : recDiff;

    wire        lastStep   = (remain_q <= {3'h0, lanes_q});
    wire        abort      = busy && !selected; // R16
    wire        advance    = busy && sclkFall;

    // Next state of the shifter; a record loads only from idle
    always_comb begin
        state_d  = state_q;
        remain_d = remain_q;
        unique case (state_q)
            RDI_IDLE: begin
                if (load) begin
                    state_d  = RDI_SHIFT;
                    remain_d = loadLen;
                end
            end
            RDI_SHIFT: begin
                if (abort) begin
                    state_d  = RDI_IDLE; // R16
                    remain_d = 6'h00;
                end else if (advance && lastStep) begin
                    state_d  = RDI_IDLE;
                    remain_d = 6'h00;
                end else if (advance) begin
                    remain_d = remain_q - {3'h0, lanes_q};
                end
            end
        endcase
    end

    // Shifter control; a host that leaves early drops the tail
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_q  <= RDI_IDLE;
            remain_q <= 6'h00;
        end else begin
            state_q  <= state_d;
            remain_q <= remain_d;
        end
    end

    // Mode and lane count frozen at record load
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            spiLatched_q <= 1'b0;
            lanes_q      <= `RDI_LANES_ONE;
        end else if (load) begin
            spiLatched_q <= spiMode; // R18
            lanes_q      <= loadLanes; // R18
        end
    end

    // Next shifter contents, MSB first, lanes bits per falling edge
    wire [`RDI_REC_W-1:0] shift_d = load    ? loadRec :             // R16
                                    advance ? (shift_q << lanes_q) : // R10
                                              shift_q;

    // Data shifter
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            shift_q <= '0;
        end else begin
            shift_q <= shift_d;
        end
    end

    // Lane mapping of the top bits; order chosen by parameter
    logic [3:0] laneNext;
    always_comb begin
        laneNext = 4'h0;
        for (int k = 0; k < 4; k++) begin
            if (k < int'(lanes_q)) begin
                if (LANE0_TAKES_MSB) begin
                    laneNext[k] = shift_q[`RDI_REC_W-1-k]; // R17
                end else begin
                    laneNext[k] = shift_q[`RDI_REC_W-int'(lanes_q)+k]; // R17
                end
            end
        end
    end

    // Output flops; idle lanes sit low, edge flop starts at the idle high
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            laneData_q <= 4'h0;
            sclkPrev_q <= 1'b1;
            echo_q     <= 1'b0;
        end else begin
            laneData_q <= busy ? laneNext : 4'h0; // R09
            sclkPrev_q <= sclkSync;
            echo_q     <= sclkSync;
        end
    end

    // Drive amplitude; a code outside the three falls back to the middle
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            drive_q <= `RDI_DRIVE_MID; // R05
        end else begin
            drive_q <= driveCode(driveRaw); // R05
        end
    end

    // Lane enables follow the frozen mode while a record runs
    wire        useSpi     = busy ? spiLatched_q : spiMode;
    wire [2:0]  useLanes   = busy ? lanes_q : laneCount(spiMode, wideLanes);
    wire [3:0]  laneMask   = (useLanes == `RDI_LANES_FOUR) ? 4'hF :
                             (useLanes == `RDI_LANES_TWO)  ? 4'h3 : 4'h1;

    // CMOS lanes drive only in CMOS mode while selected
    assign result_serial_out_lane = laneData_q;
    assign resultLaneOe           = (useSpi && selected) ? laneMask : 4'h0; // R09

    // Differential drivers are off entirely in CMOS mode
    assign diffLanePos     = laneData_q[1:0];
    assign diffLaneNeg     = ~laneData_q[1:0];
    assign diffLaneEnable  = useSpi ? 2'h0 : laneMask[1:0]; // R07 R12
    // Self clock and amplitude only matter for differential output
    assign echoClockEnable = !useSpi && !selfClock; // R07 R08
    assign echo_clock_out_pos = echoClockEnable && echo_q;
    assign echo_clock_out_neg = echoClockEnable && !echo_q;
    assign output_drive_level = useSpi ? `RDI_DRIVE_MID : drive_q; // R08

endmodule

`default_nettype wire

// >>> dv/rdi_result_port_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module rdi_result_port_monitor
    import rdi_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic       cfgWrEn,
    input wire logic [7:0] cfgAddr,
    input wire logic [7:0] cfgWrData,
    input wire logic [7:0] cfgRdData,
    input wire logic       resValid,
    input wire logic       resReady,
    input wire logic       result_serial_clock,
    input wire logic [3:0] result_serial_out_lane,
    input wire logic [3:0] resultLaneOe,
    input wire logic [1:0] diffLaneEnable,
    input wire logic       echoClockEnable,
    input wire rdi_drive_t output_drive_level
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Driver ownership: CMOS lanes and differential pairs never together
    property p_contend;
        resultLaneOe != 4'h0 |-> diffLaneEnable == 2'h0 && !echoClockEnable;
    endproperty
    a_contend: assert property (p_contend) else $error("lanes contend");
    property p_drive; resultLaneOe != 4'h0 |-> output_drive_level == 2'h1; endproperty
    a_drive: assert property (p_drive) else $error("drive level used in CMOS");
    property p_lanes;
        resultLaneOe != 4'h0 |-> resultLaneOe == 4'h1 || resultLaneOe == 4'hF;
    endproperty
    a_lanes: assert property (p_lanes) else $error("bad lane count");
    // Values seen at the first edge out of reset
    property p_rst;
        $fell(sys_rst) |-> output_drive_level == 2'h1 && diffLaneEnable == 2'h1;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset outputs");
    property p_rstA; $fell(sys_rst) && cfgAddr == 8'h15 |-> cfgRdData == 8'h00; endproperty
    a_rstA: assert property (p_rstA) else $error("bad reset value");
    property p_wr;
        cfgWrEn && cfgAddr == 8'h15 ##1 cfgAddr == 8'h15
            |-> (cfgRdData & 8'h31) == ($past(cfgWrData) & 8'h31);
    endproperty
    a_wr: assert property (p_wr) else $error("write not stored");
    property p_chk; cfgAddr == 8'h15 && cfgRdData[0] |-> !resReady; endproperty
    a_chk: assert property (p_chk) else $error("result taken in check mode");
    property p_busy; resValid && resReady |=> !resReady [*8]; endproperty
    a_busy: assert property (p_busy) else $error("result taken mid record");
    // Lanes move only shortly after a host clock fall
    property p_shift;
        // The first bit of a selection appears without a fall
        $changed(result_serial_out_lane) && resultLaneOe[0] && $past(resultLaneOe[0])
            && $past(resultLaneOe[0], 3)
            |-> !$past(result_serial_clock) || !$past(result_serial_clock, 2);
    endproperty
    a_shift: assert property (p_shift) else $error("lane moved without a fall");
    c_take: cover property (resValid && resReady);
    c_quad: cover property (resultLaneOe == 4'hF);
    c_chk: cover property (cfgAddr == 8'h15 && cfgRdData[0]);
endmodule
bind rdi_result_port rdi_result_port_monitor rdi_result_port_monitor_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .cfgWrEn(cfgWrEn), .cfgAddr(cfgAddr),
    .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .resValid(resValid), .resReady(resReady),
    .result_serial_clock(result_serial_clock), .result_serial_out_lane(result_serial_out_lane),
    .resultLaneOe(resultLaneOe), .diffLaneEnable(diffLaneEnable),
    .echoClockEnable(echoClockEnable), .output_drive_level(output_drive_level));
`default_nettype wire

// >>> dv/rdi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module rdi_host_model (
    input  wire logic       clk_sys,
    input  wire logic [3:0] laneOut,
    input  wire logic [3:0] laneOe,
    output var  logic       hostClk,
    output var  logic       hostSel_n
);
    // A released lane reads the inverse, so stale data never passes
    wire logic [3:0] pinLvl;
    assign pinLvl = (laneOe & laneOut) | (~laneOe & ~laneOut);
    initial begin
        hostClk   = 1'b1;
        hostSel_n = 1'b1;
    end
    // Clock stands high outside frames; 160 ns per step, sampled before each fall
    task automatic xfer(input int steps, input int lanes, output logic [47:0] got);
        got = 48'h0;
        @(posedge clk_sys);
        hostSel_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        for (int i = 0; i < steps; i++) begin
            @(negedge clk_sys);
            for (int k = 0; k < lanes; k++) got = {got[46:0], pinLvl[k]};
            @(posedge clk_sys);
            hostClk <= 1'b0;
            repeat (4) @(posedge clk_sys);
            hostClk <= 1'b1;
            repeat (3) @(posedge clk_sys);
        end
        hostSel_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// >>> dv/test_adc_result_data_interface.sv
`timescale 1ns/1ns
`default_nettype none
module test_adc_result_data_interface;
    import rdi_pkg::*;
    localparam logic [23:0] CRC_P = 24'h864CFB;
    localparam logic [23:0] CRC_S = 24'hFFFFFF;
    logic        clk_sys, sys_rst, cfgWrEn, resValid, chkMode;
    logic [7:0]  cfgAddr, cfgWrData, cfgRdData;
    logic [19:0] resData, d;
    logic [47:0] got;
    logic [47:0] expQ[$];
    logic        resReady, serClk, sel_n, echoClockEnable;
    logic [3:0]  lane, laneOe;
    logic [1:0]  diffLaneEnable, diffPos, diffNeg;
    logic        diffMode, echoPos, echoNeg;
    wire logic [3:0] hostLane, hostOe;
    // Host listens to the differential pairs in differential mode
    assign hostLane = diffMode ? {2'h0, diffPos} : lane;
    assign hostOe   = diffMode ? {2'h0, diffLaneEnable} : laneOe;
    rdi_drive_t  output_drive_level;
    int          err_count, cmp_count, seed;
    rdi_result_port #(.CRC_POLY(CRC_P), .CRC_SEED(CRC_S)) rdi_result_port_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .cfgWrEn(cfgWrEn), .cfgAddr(cfgAddr),
        .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .resValid(resValid),
        .resData(resData), .resReady(resReady), .result_serial_clock(serClk),
        .resultSelect_n(sel_n), .result_serial_out_lane(lane), .resultLaneOe(laneOe),
        .diffLanePos(diffPos), .diffLaneNeg(diffNeg), .echo_clock_out_pos(echoPos),
        .echo_clock_out_neg(echoNeg),
        .diffLaneEnable(diffLaneEnable), .echoClockEnable(echoClockEnable),
        .output_drive_level(output_drive_level));
    rdi_host_model rdi_host_model_inst (.clk_sys(clk_sys), .laneOut(hostLane),
        .laneOe(hostOe), .hostClk(serClk), .hostSel_n(sel_n));
    // Expected record: sign-extended value, then MSB-first CRC over it
    function automatic logic [47:0] model(input logic [19:0] v);
        logic [23:0] x, c;
        x = {{4{v[19]}}, v};
        c = CRC_S;
        for (int i = 23; i >= 0; i--) c = {c[22:0], 1'b0} ^ ((c[23] ^ x[i]) ? CRC_P : 24'h0);
        return {x, c};
    endfunction
    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic stop_test;
        $display("%0d mismatches in %0d checks", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        cfgWrEn   <= 1'b1;
        cfgAddr   <= a;
        cfgWrData <= v;
        @(posedge clk_sys);
        cfgWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        cfgAddr <= a;
        @(negedge clk_sys);
        chk(cfgRdData, e);
    endtask
    // Offer one result and hold it until the port takes it
    task automatic put(input logic [19:0] v);
        int n;
        @(posedge clk_sys);
        resValid <= 1'b1;
        resData  <= v;
        for (n = 0; n < 200 && resReady !== 1'b1; n++) @(negedge clk_sys);
        @(posedge clk_sys);
        resValid <= 1'b0;
        if (n == 200) begin
            err_count++;
            stop_test();
        end
    endtask
    // Ready must stay low for the whole pattern phase
    always @(negedge clk_sys) begin
        if (chkMode) chk(resReady, 1'b0);
    end
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        {sys_rst, cfgWrEn, resValid, chkMode} = 4'h8;
        {cfgAddr, cfgWrData, resData} = {8'h15, 28'h0};
        {err_count, cmp_count} = 0;
        diffMode = 1'b0;
        seed = $urandom(32'h18EE);
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(8'h15, 8'h00);
        rd(8'h17, 8'h01);
        rd(8'h16, 8'h00);
        chk({diffLaneEnable, echoClockEnable, output_drive_level}, 5'h0D);
        for (int i = 0; i < 3; i++) begin
            wr(8'h17, 8'(i));
            rd(8'h17, 8'(i));
            chk(output_drive_level, 48'(i));
        end
        wr(8'h15, 8'h10);
        @(negedge clk_sys);
        chk(diffLaneEnable, 2'h3);
        wr(8'h15, 8'hFF);
        rd(8'h15, 8'h31);
        chk({diffLaneEnable, echoClockEnable, output_drive_level}, 5'h01);
        chk({echoPos, echoNeg}, 2'h0);
        // Pattern only while idle, then real results must flow again
        wr(8'h15, 8'h21);
        chkMode = 1'b1;
        resValid <= 1'b1;
        resData  <= 20'h12345;
        rdi_host_model_inst.xfer(20, 1, got);
        chk(got[19:0], 20'hAC5D6);
        chkMode = 1'b0;
        resValid <= 1'b0;
        // Four CMOS records, then two differential records of 44 bits
        for (int n = 0; n < 6; n++) begin
            diffMode = (n > 3);
            wr(8'h15, {2'h0, n < 4, n[0], 4'h0});
            d = 20'($urandom);
            got = model(d);
            expQ.push_back(diffMode ? {4'h0, d, got[23:0]} : got);
            fork
                put(d);
                rdi_host_model_inst.xfer(diffMode ? (n[0] ? 22 : 44) : (n[0] ? 12 : 48),
                    n[0] ? (diffMode ? 2 : 4) : 1, got);
            join
            chk(got, expQ.pop_front());
            chk({echoPos ^ echoNeg, diffPos ^ diffNeg}, {diffMode, 2'h3});
        end
        stop_test();
    end
endmodule
`default_nettype wire
